// file: rtl/istbu_top.sv
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module istbu_top
    import istbu_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        ext_int_pin,
    input  wire logic        overvoltage_detector,
    input  wire logic        lowvoltage_detector,
    input  wire logic        sine_wave_edge_function,
    input  wire logic        timebase_input_clock,
    input  wire logic [1:0]  timer_period_match,
    input  wire logic [1:0]  timer_compare_match,
    input  wire logic        stack_full,
    input  wire logic        vector_ack,
    output logic             vector_req_q,
    output logic      [2:0]  vector_idx_q,
    output logic             wakeup_q
);
    logic [1:0] edge_select_field_q;
    logic       global_irq_en_q, ext_pin_irq_en_q, overvolt_irq_en_q, lowvolt_irq_en_q;
    logic       sine_edge_irq_en_q;
    logic [1:0] timebase_irq_en_q, shared_irq_en_q;
    logic       ext_pin_req_flag_q, overvolt_req_flag_q, lowvolt_req_flag_q;
    logic       sine_edge_req_flag_q;
    logic [1:0] timebase_req_flag_q, shared_req_flag_q;
    logic [1:0] timer_period_match_flag_q, timer_compare_match_flag_q;
    logic [1:0] timer_period_match_en_q, timer_compare_match_en_q;
    logic [7:0] time_base_config_q;

    // bus
    logic       wr_pend_q;
    logic [7:0] wr_addr_q;
    logic       rd_go;
    logic       wr_go;
    logic [7:0] wd;
    assign rd_go = hsel && hready && htrans == ISTBU_HTRANS_NONSEQ && !hwrite;
    assign wr_go = wr_pend_q;
    assign wd    = hwdata[7:0];

    function automatic logic wr_at(input logic [7:0] ofs);
        wr_at = wr_go && wr_addr_q == ofs;
    endfunction

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= hsel && hready && htrans == ISTBU_HTRANS_NONSEQ && hwrite;
            wr_addr_q <= haddr;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // pin and sources: three stage synchronisers
    logic [2:0] pin_sync_q, ovp_sync_q, lvd_sync_q, sin_sync_q, tbc_sync_q;
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            pin_sync_q <= 3'h0;
            ovp_sync_q <= 3'h0;
            lvd_sync_q <= 3'h0;
            sin_sync_q <= 3'h0;
            tbc_sync_q <= 3'h0;
        end else begin
            // pull-high on the pin is a pad matter and is left untouched here
            pin_sync_q <= {pin_sync_q[1:0], ext_int_pin};
            ovp_sync_q <= {ovp_sync_q[1:0], overvoltage_detector};
            lvd_sync_q <= {lvd_sync_q[1:0], lowvoltage_detector};
            sin_sync_q <= {sin_sync_q[1:0], sine_wave_edge_function};
            tbc_sync_q <= {tbc_sync_q[1:0], timebase_input_clock};
        end
    end

    function automatic logic rose(input logic [2:0] s);
        rose = s[1] && !s[2];
    endfunction
    function automatic logic fell(input logic [2:0] s);
        fell = !s[1] && s[2];
    endfunction

    logic pin_evt;
    always_comb begin
        unique case (edge_select_field_q)
            ISTBU_EDGE_OFF:  pin_evt = 1'b0;
            ISTBU_EDGE_RISE: pin_evt = rose(pin_sync_q);
            ISTBU_EDGE_FALL: pin_evt = fell(pin_sync_q);
            ISTBU_EDGE_BOTH: pin_evt = rose(pin_sync_q) || fell(pin_sync_q);
        endcase
    end

    // time base clock: dedicated clock edge or system clock divided by four
    logic [1:0]  sys_div_q;
    logic [15:0] tb_cnt_q;
    logic        tb_tick;
    always_ff @(posedge mclk) begin
        if (!rst_b) sys_div_q <= 2'h0;
        else        sys_div_q <= sys_div_q + 2'h1;
    end
    assign tb_tick = time_base_config_q[ISTBU_TBC_CK] ? (sys_div_q == ISTBU_SYS_DIV_LAST)
                                                      : rose(tbc_sync_q);

    always_ff @(posedge mclk) begin
        if (!rst_b) tb_cnt_q <= 16'h0000;
        else if (!time_base_config_q[ISTBU_TBC_ON]) tb_cnt_q <= 16'h0000;
        else if (tb_tick) tb_cnt_q <= tb_cnt_q + 16'h0001;
    end

    // overflow when all bits below the selected exponent are set on a tick
    function automatic logic tb_ovf(input logic [15:0] cnt, input logic [3:0] ex);
        logic [15:0] m;
        m = (16'h0001 << ex) - 16'h0001;
        tb_ovf = (cnt & m) == m;
    endfunction
    logic [1:0] tb_evt;
    assign tb_evt[0] = time_base_config_q[ISTBU_TBC_ON] && tb_tick &&
        tb_ovf(tb_cnt_q, ISTBU_TB0_EXP_BASE + {1'b0, time_base_config_q[2:0]});
    assign tb_evt[1] = time_base_config_q[ISTBU_TBC_ON] && tb_tick &&
        tb_ovf(tb_cnt_q, ISTBU_TB1_EXP_BASE + {2'b00, time_base_config_q[5:4]});

    // arbitration
    logic [ISTBU_NSRC-1:0] pend;
    logic [ISTBU_NSRC-1:0] all_flags;
    logic [1:0]            tmr_vec_ok;
    logic                  any_pend;
    logic [2:0]            win;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tmr
            assign tmr_vec_ok[gi] = (timer_period_match_flag_q[gi] && timer_period_match_en_q[gi])
                || (timer_compare_match_flag_q[gi] && timer_compare_match_en_q[gi]);
        end
    endgenerate
    assign pend[ISTBU_SRC_PIN] = ext_pin_req_flag_q && ext_pin_irq_en_q;
    assign pend[ISTBU_SRC_OVP] = overvolt_req_flag_q && overvolt_irq_en_q;
    assign pend[ISTBU_SRC_LVD] = lowvolt_req_flag_q && lowvolt_irq_en_q;
    assign pend[ISTBU_SRC_SH0] = shared_req_flag_q[0] && shared_irq_en_q[0] && tmr_vec_ok[0];
    assign pend[ISTBU_SRC_SH1] = shared_req_flag_q[1] && shared_irq_en_q[1] && tmr_vec_ok[1];
    assign pend[ISTBU_SRC_TB0] = timebase_req_flag_q[0] && timebase_irq_en_q[0];
    assign pend[ISTBU_SRC_TB1] = timebase_req_flag_q[1] && timebase_irq_en_q[1];
    assign pend[ISTBU_SRC_SIN] = sine_edge_req_flag_q && sine_edge_irq_en_q;
    assign any_pend = |pend && global_irq_en_q && !stack_full;

    always_comb begin
        win = 3'h0;
        for (int i = ISTBU_NSRC - 1; i >= 0; i--) begin
            if (pend[i]) win = 3'(i);
        end
    end

    // request held until acknowledged; the core takes one vector at a time
    logic svc;
    assign svc = vector_req_q && vector_ack;
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            vector_req_q <= 1'b0;
            vector_idx_q <= 3'h0;
        end else if (svc) begin
            vector_req_q <= 1'b0;
        end else if (!vector_req_q && any_pend) begin
            vector_req_q <= 1'b1;
            vector_idx_q <= win;
        end
    end

    function automatic logic svc_of(input int s);
        svc_of = svc && vector_idx_q == 3'(s);
    endfunction

    // enables and config; service clearing global beats a software write
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            global_irq_en_q <= 1'b0;
            ext_pin_irq_en_q <= 1'b0;
            timebase_irq_en_q <= 2'h0;
            overvolt_irq_en_q <= 1'b0;
            lowvolt_irq_en_q <= 1'b0;
            shared_irq_en_q <= 2'h0;
            sine_edge_irq_en_q <= 1'b0;
            timer_period_match_en_q <= 2'h0;
            timer_compare_match_en_q <= 2'h0;
            edge_select_field_q <= ISTBU_EDGE_OFF;
            time_base_config_q <= ISTBU_TBC_RST;
        end else begin
            if (wr_at(ISTBU_OFS_EDGE)) edge_select_field_q <= wd[1:0];
            if (wr_at(ISTBU_OFS_CTL0)) begin
                global_irq_en_q   <= wd[0];
                ext_pin_irq_en_q  <= wd[1];
                timebase_irq_en_q <= wd[3:2];
            end
            if (wr_at(ISTBU_OFS_CTL1)) begin
                shared_irq_en_q   <= wd[1:0];
                overvolt_irq_en_q <= wd[2];
                lowvolt_irq_en_q  <= wd[3];
            end
            if (wr_at(ISTBU_OFS_CTL2)) sine_edge_irq_en_q <= wd[0];
            if (wr_at(ISTBU_OFS_TMR0)) begin
                timer_period_match_en_q[0]  <= wd[0];
                timer_compare_match_en_q[0] <= wd[1];
            end
            if (wr_at(ISTBU_OFS_TMR1)) begin
                timer_period_match_en_q[1]  <= wd[0];
                timer_compare_match_en_q[1] <= wd[1];
            end
            if (wr_at(ISTBU_OFS_TBC)) time_base_config_q <= wd & ISTBU_TBC_MASK;
            if (svc) global_irq_en_q <= 1'b0;
        end
    end

    // request flags: hardware set wins over clear, both by write and by service
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            ext_pin_req_flag_q <= 1'b0;
            overvolt_req_flag_q <= 1'b0;
            lowvolt_req_flag_q <= 1'b0;
            sine_edge_req_flag_q <= 1'b0;
            timebase_req_flag_q <= 2'h0;
        end else begin
            if (wr_at(ISTBU_OFS_CTL0)) begin
                ext_pin_req_flag_q  <= wd[4];
                timebase_req_flag_q <= wd[6:5];
            end
            if (wr_at(ISTBU_OFS_CTL1)) begin
                overvolt_req_flag_q <= wd[6];
                lowvolt_req_flag_q  <= wd[7];
            end
            if (wr_at(ISTBU_OFS_CTL2)) sine_edge_req_flag_q <= wd[4];
            if (svc_of(ISTBU_SRC_PIN)) ext_pin_req_flag_q <= 1'b0;
            if (svc_of(ISTBU_SRC_OVP)) overvolt_req_flag_q <= 1'b0;
            if (svc_of(ISTBU_SRC_LVD)) lowvolt_req_flag_q <= 1'b0;
            if (svc_of(ISTBU_SRC_SIN)) sine_edge_req_flag_q <= 1'b0;
            if (svc_of(ISTBU_SRC_TB0)) timebase_req_flag_q[0] <= 1'b0;
            if (svc_of(ISTBU_SRC_TB1)) timebase_req_flag_q[1] <= 1'b0;
            if (pin_evt) ext_pin_req_flag_q <= 1'b1;
            if (rose(ovp_sync_q)) overvolt_req_flag_q <= 1'b1;
            if (rose(lvd_sync_q)) lowvolt_req_flag_q <= 1'b1;
            if (rose(sin_sync_q)) sine_edge_req_flag_q <= 1'b1;
            if (tb_evt[0]) timebase_req_flag_q[0] <= 1'b1;
            if (tb_evt[1]) timebase_req_flag_q[1] <= 1'b1;
        end
    end

    // timer flags: matches are same-clock pulses, software alone clears the match flags, service also clears the shared flags
    logic [1:0] tmr_set;
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            timer_period_match_flag_q  <= 2'h0;
            timer_compare_match_flag_q <= 2'h0;
            shared_req_flag_q          <= 2'h0;
        end else begin
            if (wr_at(ISTBU_OFS_CTL1)) shared_req_flag_q <= wd[5:4];
            if (wr_at(ISTBU_OFS_TMR0)) begin
                timer_period_match_flag_q[0]  <= wd[4];
                timer_compare_match_flag_q[0] <= wd[5];
            end
            if (wr_at(ISTBU_OFS_TMR1)) begin
                timer_period_match_flag_q[1]  <= wd[4];
                timer_compare_match_flag_q[1] <= wd[5];
            end
            if (svc_of(ISTBU_SRC_SH0)) shared_req_flag_q[0] <= 1'b0;
            if (svc_of(ISTBU_SRC_SH1)) shared_req_flag_q[1] <= 1'b0;
            for (int i = 0; i < 2; i++) begin
                if (timer_period_match[i])  timer_period_match_flag_q[i]  <= 1'b1;
                if (timer_compare_match[i]) timer_compare_match_flag_q[i] <= 1'b1;
                if (tmr_set[i]) shared_req_flag_q[i] <= 1'b1;
            end
        end
    end
    generate
        for (gi = 0; gi < 2; gi++) begin : g_sh
            assign tmr_set[gi] = (timer_period_match[gi] && !timer_period_match_flag_q[gi])
                || (timer_compare_match[gi] && !timer_compare_match_flag_q[gi]);
        end
    endgenerate

    // wake-up on any flag going high, enables ignored
    logic [11:0] flags_now, flags_prev_q;
    assign all_flags = {sine_edge_req_flag_q, timebase_req_flag_q, shared_req_flag_q,
                        lowvolt_req_flag_q, overvolt_req_flag_q, ext_pin_req_flag_q};
    assign flags_now = {all_flags, timer_period_match_flag_q, timer_compare_match_flag_q};
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            flags_prev_q <= 12'h000;
            wakeup_q     <= 1'b0;
        end else begin
            flags_prev_q <= flags_now;
            wakeup_q     <= |(flags_now & ~flags_prev_q);
        end
    end

    // read data
    logic [7:0] rd_mux;
    always_comb begin
        unique case (haddr)
            ISTBU_OFS_EDGE: rd_mux = {6'h00, edge_select_field_q};
            ISTBU_OFS_CTL0: rd_mux = {1'b0, timebase_req_flag_q, ext_pin_req_flag_q,
                                      timebase_irq_en_q, ext_pin_irq_en_q, global_irq_en_q};
            ISTBU_OFS_CTL1: rd_mux = {lowvolt_req_flag_q, overvolt_req_flag_q, shared_req_flag_q,
                                      lowvolt_irq_en_q, overvolt_irq_en_q, shared_irq_en_q};
            ISTBU_OFS_CTL2: rd_mux = {3'h0, sine_edge_req_flag_q, 3'h0, sine_edge_irq_en_q};
            ISTBU_OFS_TMR0: rd_mux = {2'h0, timer_compare_match_flag_q[0],
                                      timer_period_match_flag_q[0], 2'h0,
                                      timer_compare_match_en_q[0], timer_period_match_en_q[0]};
            ISTBU_OFS_TMR1: rd_mux = {2'h0, timer_compare_match_flag_q[1],
                                      timer_period_match_flag_q[1], 2'h0,
                                      timer_compare_match_en_q[1], timer_period_match_en_q[1]};
            ISTBU_OFS_TBC:  rd_mux = time_base_config_q & ISTBU_TBC_MASK;
            ISTBU_OFS_STAT: rd_mux = {vector_req_q, 4'h0, vector_idx_q};
            default:        rd_mux = 8'h00;
        endcase
    end
    always_ff @(posedge mclk) begin
        if (!rst_b)     hrdata <= 32'h0000_0000;
        else if (rd_go) hrdata <= {24'h00_0000, rd_mux};
    end
    // is kept by software: pin routing and port direction live outside this unit
endmodule // istbu_top

// file: pkg/istbu_pkg.sv
package istbu_pkg;
    localparam logic [7:0] ISTBU_OFS_EDGE = 8'h00;
    localparam logic [7:0] ISTBU_OFS_CTL0 = 8'h04;
    localparam logic [7:0] ISTBU_OFS_CTL1 = 8'h08;
    localparam logic [7:0] ISTBU_OFS_CTL2 = 8'h0c;
    localparam logic [7:0] ISTBU_OFS_TMR0 = 8'h10;
    localparam logic [7:0] ISTBU_OFS_TMR1 = 8'h14;
    localparam logic [7:0] ISTBU_OFS_TBC  = 8'h18;
    localparam logic [7:0] ISTBU_OFS_STAT = 8'h1c;
    localparam logic [7:0] ISTBU_TBC_RST  = 8'h37;
    localparam logic [7:0] ISTBU_TBC_MASK = 8'hf7;
    localparam int ISTBU_TBC_ON   = 7;
    localparam int ISTBU_TBC_CK   = 6;
    localparam logic [1:0] ISTBU_EDGE_OFF  = 2'h0;
    localparam logic [1:0] ISTBU_EDGE_RISE = 2'h1;
    localparam logic [1:0] ISTBU_EDGE_FALL = 2'h2;
    localparam logic [1:0] ISTBU_EDGE_BOTH = 2'h3;
    localparam logic [3:0] ISTBU_TB0_EXP_BASE = 4'h8;
    localparam logic [3:0] ISTBU_TB1_EXP_BASE = 4'hc;
    localparam logic [1:0] ISTBU_SYS_DIV_LAST = 2'h3;
    // source index: lower index wins when several are pending
    localparam int ISTBU_NSRC = 8;
    localparam int ISTBU_SRC_PIN = 0;
    localparam int ISTBU_SRC_OVP = 1;
    localparam int ISTBU_SRC_LVD = 2;
    localparam int ISTBU_SRC_SH0 = 3;
    localparam int ISTBU_SRC_SH1 = 4;
    localparam int ISTBU_SRC_TB0 = 5;
    localparam int ISTBU_SRC_TB1 = 6;
    localparam int ISTBU_SRC_SIN = 7;
    localparam logic [1:0] ISTBU_HTRANS_NONSEQ = 2'h2;
endpackage

// file: tb/istbu_chk.sv
`timescale 1ns/1ps
module istbu_chk
    import istbu_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        hsel,
    input wire logic [7:0]  haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        stack_full,
    input wire logic        vector_ack,
    input wire logic        vector_req_q,
    input wire logic [2:0]  vector_idx_q
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    logic rd_a;
    assign rd_a = hsel && hready && htrans == ISTBU_HTRANS_NONSEQ && !hwrite;
    AST_READY: assert property (hreadyout)
        else $error("hreadyout low");
    AST_OKAY: assert property (!hresp)
        else $error("hresp not okay");
    AST_REQ_HOLD: assert property (vector_req_q && !vector_ack |=> vector_req_q)
        else $error("vector request dropped before ack");
    AST_IDX_HOLD: assert property (vector_req_q && !vector_ack |=> $stable(vector_idx_q))
        else $error("vector index changed while pending");
    AST_REQ_DROP: assert property (vector_req_q && vector_ack |=> !vector_req_q)
        else $error("vector request held after ack");
    AST_STACK: assert property ($rose(vector_req_q) |-> !$past(stack_full))
        else $error("vector raised while stack full");
    AST_TBC_B3: assert property (rd_a && haddr == ISTBU_OFS_TBC |=> hrdata[3] == 1'b0)
        else $error("unimplemented config bit reads one");
    AST_UNMAPPED: assert property (rd_a && haddr == 8'h20 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    cover property (vector_req_q && vector_ack);
    cover property (stack_full && !vector_req_q ##1 !stack_full);
    cover property (rd_a && haddr == ISTBU_OFS_TBC);
endmodule // istbu_chk

bind istbu_top istbu_chk u_chk (
    .mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .stack_full(stack_full), .vector_ack(vector_ack),
    .vector_req_q(vector_req_q), .vector_idx_q(vector_idx_q)
);

// file: tb/istbu_core_model.sv
`timescale 1ns/1ps
module istbu_core_model (
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire logic       vector_req_q,
    input  wire logic [3:0] ack_delay,
    input  wire logic       full_cmd,
    output logic            vector_ack,
    output logic            stack_full
);
    logic [3:0] wait_q;
    // stack depth is not modelled; the bench commands a full stack directly
    assign stack_full = full_cmd;
    always_ff @(posedge mclk) begin
        if (!rst_b) begin
            wait_q     <= 4'h0;
            vector_ack <= 1'b0;
        end else if (vector_req_q && vector_ack) begin
            wait_q     <= 4'h0;
            vector_ack <= 1'b0;
        end else if (vector_req_q) begin
            wait_q     <= wait_q + 4'h1;
            vector_ack <= (wait_q >= ack_delay);
        end
    end
endmodule // istbu_core_model

// file: tb/tb_interrupt_source_and_time_base_unit.sv
`timescale 1ns/1ps
module tb_interrupt_source_and_time_base_unit;
    import istbu_pkg::*;
    logic        mclk, rst_b, hsel, hwrite, ext_int_pin, tbclk, full_cmd, rd_pend, s_v;
    logic        hreadyout, hresp, stack_full, vector_ack, vector_req_q, wakeup_q;
    logic [1:0]  htrans, tm_per, tm_cmp;
    logic [2:0]  hsize, det_v, vector_idx_q;
    logic [3:0]  ack_delay;
    logic [7:0]  haddr, a_v;
    logic [31:0] hwdata, hrdata, e_v;
    logic [31:0] rq[$];
    logic [2:0]  vq[$];
    int          fail_count, num_checks, cyc, wake_cnt, w0, ew, t0;

    istbu_top uut (.mclk(mclk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .ext_int_pin(ext_int_pin),
        .overvoltage_detector(det_v[0]), .lowvoltage_detector(det_v[1]),
        .sine_wave_edge_function(det_v[2]), .timebase_input_clock(tbclk),
        .timer_period_match(tm_per), .timer_compare_match(tm_cmp), .stack_full(stack_full),
        .vector_ack(vector_ack), .vector_req_q(vector_req_q), .vector_idx_q(vector_idx_q),
        .wakeup_q(wakeup_q));
    istbu_core_model u_core (.mclk(mclk), .rst_b(rst_b), .vector_req_q(vector_req_q),
        .ack_delay(ack_delay), .full_cmd(full_cmd), .vector_ack(vector_ack),
        .stack_full(stack_full));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // slow dedicated time-base clock, deliberately not a multiple of mclk
    initial begin
        tbclk = 1'b0;
        forever #1237 tbclk = ~tbclk;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks=%0d mismatches=%0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic edge_rdy();
        int n;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            fail_count++;
            final_report();
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= a;
        hwrite <= w;
        htrans <= ISTBU_HTRANS_NONSEQ;
        edge_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        edge_rdy();
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        rq.push_back(e);
        ahb(1'b0, a, 32'h0);
    endtask
    task automatic wait_vec(input int lim);
        int n;
        n = 0;
        while (vq.size() > 0 && n < lim) begin
            @(posedge mclk);
            n++;
        end
        if (vq.size() > 0) begin
            fail_count++;
            final_report();
        end
    endtask
    task automatic tmeas(input logic [2:0] i, input int lo, input int hi);
        int n;
        n = 0;
        while (vector_req_q !== 1'b1 && n < 20000) begin
            @(posedge mclk);
            n++;
        end
        chk({31'h0, (cyc - t0 >= lo && cyc - t0 <= hi)}, 32'h1);
        vq.push_back(i);
        wait_vec(40);
    endtask

    // read data and vector takes are checked against the oldest note
    always @(posedge mclk) begin
        cyc++;
        if (wakeup_q === 1'b1) wake_cnt++;
        if (rd_pend) chk(hrdata, rq.pop_front());
        rd_pend <= hsel && hreadyout && htrans == ISTBU_HTRANS_NONSEQ && !hwrite;
        if (vector_req_q === 1'b1 && vector_ack === 1'b1)
            chk({29'h0, vector_idx_q}, vq.size() > 0 ? {29'h0, vq.pop_front()} : 32'hffff);
    end

    initial begin
        fail_count = 0; num_checks = 0; cyc = 0; wake_cnt = 0; rd_pend = 1'b0;
        rst_b = 1'b0; hsel = 1'b0; haddr = 8'h0; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = 32'h0; ext_int_pin = 1'b0; det_v = 3'h0;
        tm_per = 2'h0; tm_cmp = 2'h0; full_cmd = 1'b0;
        void'($urandom(32'h18cf));
        ack_delay = 4'($urandom % 4);
        repeat (6) @(posedge mclk);
        rst_b <= 1'b1;
        @(posedge mclk);
        rd(ISTBU_OFS_TBC, 32'h37);
        wr(ISTBU_OFS_TBC, 32'hff);
        rd(ISTBU_OFS_TBC, 32'hf7);
        wr(ISTBU_OFS_TBC, 32'h37);
        rd(8'h20, 32'h0);
        w0 = wake_cnt;
        ew = 0;
        for (int c = 0; c < 4; c++) begin
            wr(ISTBU_OFS_EDGE, 32'(c));
            rd(ISTBU_OFS_EDGE, 32'(c));
            wr(ISTBU_OFS_CTL0, 32'h0);
            ext_int_pin <= 1'b1;
            idle(8);
            rd(ISTBU_OFS_CTL0, c[0] ? 32'h10 : 32'h0);
            wr(ISTBU_OFS_CTL0, 32'h0);
            ext_int_pin <= 1'b0;
            idle(8);
            rd(ISTBU_OFS_CTL0, c[1] ? 32'h10 : 32'h0);
            ew += c[0] + c[1];
        end
        chk(wake_cnt - w0, ew);
        wr(ISTBU_OFS_EDGE, 32'h1);
        wr(ISTBU_OFS_CTL0, 32'h3);
        full_cmd <= 1'b1;
        ext_int_pin <= 1'b1;
        idle(10);
        chk({31'h0, vector_req_q}, 32'h0);
        rd(ISTBU_OFS_STAT, 32'h0);
        vq.push_back(3'h0);
        full_cmd <= 1'b0;
        wait_vec(40);
        rd(ISTBU_OFS_CTL0, 32'h2);
        ext_int_pin <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            a_v = (k == 2) ? ISTBU_OFS_CTL2 : ISTBU_OFS_CTL1;
            e_v = (k == 0) ? 32'h4 : (k == 1) ? 32'h8 : 32'h1;
            wr(a_v, e_v);
            wr(ISTBU_OFS_CTL0, 32'h1);
            vq.push_back(k == 0 ? 3'h1 : k == 1 ? 3'h2 : 3'h7);
            det_v <= 3'(1 << k);
            wait_vec(40);
            rd(a_v, e_v);
            rd(ISTBU_OFS_CTL0, 32'h0);
            det_v <= 3'h0;
        end
        wr(ISTBU_OFS_CTL1, 32'h4);
        wr(ISTBU_OFS_CTL0, 32'h2);
        ext_int_pin <= 1'b1;
        det_v <= 3'h1;
        idle(8);
        vq.push_back(3'h0);
        // keep the latched pin flag set while turning on global and pin enables
        wr(ISTBU_OFS_CTL0, 32'h13);
        wait_vec(40);
        rd(ISTBU_OFS_CTL1, 32'h44);
        vq.push_back(3'h1);
        wr(ISTBU_OFS_CTL0, 32'h1);
        wait_vec(40);
        det_v <= 3'h0;
        for (int t = 0; t < 2; t++) begin
            s_v = 1'($urandom % 2);
            a_v = ISTBU_OFS_TMR0 + 8'(4 * t);
            wr(a_v, s_v ? 32'h2 : 32'h1);
            wr(ISTBU_OFS_CTL1, 32'(1 << t));
            if (s_v) tm_cmp[t] <= 1'b1;
            else tm_per[t] <= 1'b1;
            @(posedge mclk);
            tm_cmp <= 2'h0;
            tm_per <= 2'h0;
            vq.push_back(3'(3 + t));
            wr(ISTBU_OFS_CTL0, 32'h1);
            wait_vec(40);
            rd(ISTBU_OFS_CTL1, 32'(1 << t));
            rd(a_v, s_v ? 32'h22 : 32'h11);
        end
        wr(ISTBU_OFS_CTL0, 32'h5);
        wr(ISTBU_OFS_TBC, 32'hc0);
        t0 = cyc;
        tmeas(3'h5, 1016, 1036);
        wr(ISTBU_OFS_CTL0, 32'h9);
        tmeas(3'h6, 16376, 16396);
        wr(ISTBU_OFS_TBC, 32'h0);
        wr(ISTBU_OFS_CTL0, 32'h5);
        wr(ISTBU_OFS_TBC, 32'h80);
        t0 = cyc;
        tmeas(3'h5, 12590, 12700);
        final_report();
    end
endmodule // tb_interrupt_source_and_time_base_unit
